/* File: ocdac_serial_port.sv */
// serial write port and double-buffered channel registers of an octal dac
//
// Overview of operation
// - strap high at power-up: data sampled on serial clock rising edge
// - strap low at power-up: data sampled on serial clock falling edge
// - first rising edge of the strap after power-up enters frame-sync mode
// - each write is captured in a sixteen-bit shift register
// - a frame may arrive as one word or two bytes under one select
// - frames travel most significant bit first
// - top four bits are the command, low twelve bits the code
// - ten-bit variant uses top ten code bits, low two are sub-bits
// - eight-bit variant uses top eight code bits, low four are sub-bits
// - each of eight channels has an input and an output register
// - at power-up every output takes the level chosen by the level strap
// - a write may load the input register and leave the output alone
// - the output register may be copied from the input register
// - a write may load input and output registers together
// - level strap high gives full scale, low zero, open midscale
// - code width is twelve, ten or eight bits by variant
`timescale 1ns/10ps
`include "ocdac_regs.svh"
module ocdac_serial_port #(
   parameter int CODE_BITS = `OCDAC_CODE_MAX_BITS,
   parameter int CHANNELS = `OCDAC_CHANNELS
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // serial pins from the host
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic din,
   // straps
   input wire logic edge_sel,
   input wire logic power_up_level_strap,
   input wire logic pu_open,
   // local control
   input wire logic apply_hold,
   input wire logic update_all,
   // status
   output logic ready,
   output logic sample_on_rise,
   output logic frame_sync_mode,
   output logic frame_ready,
   output logic overrun,
   // channel output codes
   output logic [CHANNELS*CODE_BITS-1:0] out_code
);
   localparam logic [CODE_BITS-1:0] CODE_FULL = '1;
   localparam logic [CODE_BITS-1:0] CODE_MID = {1'b1, {(CODE_BITS-1){1'b0}}};
   logic [5:0] sync1, sync2;
   logic sclk_d, edge_d;
   logic sclk_s, cs_n_s, din_s, edge_s, pu_level_s, pu_open_s;
   logic sclk_rise, sclk_fall, active_edge;
   ocdac_pkg::ocdac_state_t state;
   logic [1:0] init_cnt;
   logic init_go;
   ocdac_pkg::ocdac_pu_t pu_sel;
   logic [CODE_BITS-1:0] init_code;
   logic [4:0] bit_cnt;
   logic [15:0] shreg, frame_word;
   logic shift_en, push;
   logic [15:0] fifo [2];
   logic wr_ptr, rd_ptr;
   logic [1:0] cnt, next_cnt;
   logic do_push, pop;
   logic [15:0] head;
   logic [3:0] head_cmd;
   logic [2:0] head_ch;
   logic head_both, update_run;
   logic [CODE_BITS-1:0] head_code;
   logic [CODE_BITS-1:0] in_val [CHANNELS], out_val [CHANNELS];
   logic [2:0] last_ch;
   logic [CODE_BITS-1:0] sel_out;

   // two-stage synchronisers for pins and straps
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         sync1 <= `OCDAC_SYNC_RESET;
         sync2 <= `OCDAC_SYNC_RESET;
      end else begin
         sync1 <= {pu_open, power_up_level_strap, edge_sel, din, cs_n, sclk};
         sync2 <= sync1;
      end
   end

   assign sclk_s = sync2[0];
   assign cs_n_s = sync2[1];
   assign din_s = sync2[2];
   assign edge_s = sync2[3];
   assign pu_level_s = sync2[4];
   assign pu_open_s = sync2[5];

   // edge detection history
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         sclk_d <= 1'b0;
         edge_d <= 1'b0;
      end else begin
         sclk_d <= sclk_s;
         edge_d <= edge_s;
      end
   end

   assign sclk_rise = sclk_s & ~sclk_d;
   assign sclk_fall = ~sclk_s & sclk_d;
   assign active_edge = (sample_on_rise && !frame_sync_mode) ? sclk_rise :
      sclk_fall;

   // power-up sequence
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         state <= ocdac_pkg::st_init;
         init_cnt <= 2'h0;
         init_go <= 1'b0;
         ready <= 1'b0;
      end else begin
         case (state)
            ocdac_pkg::st_init: begin
               if (init_cnt == `OCDAC_INIT_WAIT) begin
                  state <= ocdac_pkg::st_run;
                  init_go <= 1'b1;
                  ready <= 1'b1;
               end else begin
                  init_cnt <= init_cnt + 2'h1;
               end
            end
            ocdac_pkg::st_run: begin
               init_go <= 1'b0;
            end
            default: begin
               state <= ocdac_pkg::st_init;
            end
         endcase
      end
   end

   // strap capture after reset release
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         sample_on_rise <= 1'b0;
         pu_sel <= ocdac_pkg::pu_zero;
      end else if (state == ocdac_pkg::st_init &&
         init_cnt == `OCDAC_INIT_WAIT) begin
         sample_on_rise <= edge_s;
         if (pu_open_s) begin
            pu_sel <= ocdac_pkg::pu_mid;
         end else if (pu_level_s) begin
            pu_sel <= ocdac_pkg::pu_full;
         end else begin
            pu_sel <= ocdac_pkg::pu_zero;
         end
      end
   end

   always_comb begin
      case (pu_sel)
         ocdac_pkg::pu_full: init_code = CODE_FULL;
         ocdac_pkg::pu_mid: init_code = CODE_MID;
         default: init_code = '0;
      endcase
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         frame_sync_mode <= 1'b0;
      end else if (state == ocdac_pkg::st_run && edge_s && !edge_d) begin
         frame_sync_mode <= 1'b1;
      end
   end

   assign shift_en = state == ocdac_pkg::st_run && !cs_n_s && active_edge &&
      bit_cnt < `OCDAC_FRAME_BITS;
   assign frame_word = {shreg[14:0], din_s};
   assign push = shift_en && bit_cnt == `OCDAC_LAST_BIT;

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         bit_cnt <= 5'h00;
         shreg <= 16'h0000;
      end else if (cs_n_s) begin
         bit_cnt <= 5'h00;
      end else if (shift_en) begin
         shreg <= frame_word;
         bit_cnt <= bit_cnt + 5'h01;
      end
   end

   // two-entry frame buffer
   assign do_push = push && cnt != `OCDAC_BUF_FULL;
   assign pop = state == ocdac_pkg::st_run && cnt != 2'h0 && !apply_hold;

   always_comb begin
      case ({do_push, pop})
         2'b10: next_cnt = cnt + 2'h1;
         2'b01: next_cnt = cnt - 2'h1;
         default: next_cnt = cnt;
      endcase
   end

   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         fifo[0] <= 16'h0000;
         fifo[1] <= 16'h0000;
         wr_ptr <= 1'b0;
         rd_ptr <= 1'b0;
         cnt <= 2'h0;
         frame_ready <= 1'b0;
      end else begin
         if (do_push) begin
            fifo[wr_ptr] <= frame_word;
            wr_ptr <= ~wr_ptr;
         end
         if (pop) begin
            rd_ptr <= ~rd_ptr;
         end
         cnt <= next_cnt;
         frame_ready <= state == ocdac_pkg::st_run &&
            next_cnt != `OCDAC_BUF_FULL;
      end
   end

   // sticky loss flag
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         overrun <= 1'b0;
      end else if (push && !do_push) begin
         overrun <= 1'b1;
      end
   end

   assign head = fifo[rd_ptr];
   assign head_cmd = head[`OCDAC_CMD_MSB:`OCDAC_CMD_LSB];
   assign head_ch = head_cmd[2:0];
   assign head_both = head_cmd[`OCDAC_BOTH_BIT];
   assign head_code = head[`OCDAC_CODE_MSB -: CODE_BITS];
   assign update_run = state == ocdac_pkg::st_run && update_all;

   ocdac_ch_if #(.W(CODE_BITS)) ch_if [CHANNELS] ();
   generate
      for (genvar i = 0; i < CHANNELS; i++) begin : g_ch
         // load input, or input and output
         assign ch_if[i].load_in = pop && head_ch == 3'(i);
         assign ch_if[i].load_out = pop && head_both && head_ch == 3'(i);
         assign ch_if[i].copy = update_run;
         assign ch_if[i].init = init_go;
         assign ch_if[i].code = head_code;
         assign ch_if[i].init_code = init_code;
         assign in_val[i] = ch_if[i].in_reg;
         assign out_val[i] = ch_if[i].out_reg;
         assign out_code[i*CODE_BITS +: CODE_BITS] = ch_if[i].out_reg;
         ocdac_chan_reg #(.W(CODE_BITS)) u_reg (
            .ref_clk(ref_clk),
            .nrst(nrst),
            .bus(ch_if[i].chan)
         );
      end
   endgenerate

   // checking helpers
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         last_ch <= 3'h0;
      end else begin
         last_ch <= head_ch;
      end
   end
   assign sel_out = out_val[head_ch];

   property p_count_limit;
      @(posedge ref_clk) disable iff (!nrst)
      bit_cnt <= `OCDAC_FRAME_BITS;
   endproperty
   a_count_limit: assert property (p_count_limit)
      else $error("bit count past sixteen");

   property p_push_full;
      @(posedge ref_clk) disable iff (!nrst)
      push |=> bit_cnt == `OCDAC_FRAME_BITS;
   endproperty
   a_push_full: assert property (p_push_full)
      else $error("frame pushed before sixteen bits");

   property p_cs_discard;
      @(posedge ref_clk) disable iff (!nrst)
      cs_n_s |=> bit_cnt == 5'h00 && !$past(push);
   endproperty
   a_cs_discard: assert property (p_cs_discard)
      else $error("partial frame kept after deselect");

   property p_rise_only;
      @(posedge ref_clk) disable iff (!nrst)
      sample_on_rise && !frame_sync_mode && sclk_fall && !cs_n_s
         |=> $stable(bit_cnt);
   endproperty
   a_rise_only: assert property (p_rise_only)
      else $error("shifted on falling edge in rising mode");

   property p_fall_mode;
      @(posedge ref_clk) disable iff (!nrst)
      state == ocdac_pkg::st_run && !sample_on_rise && sclk_fall &&
         !cs_n_s && bit_cnt < `OCDAC_FRAME_BITS
         |=> bit_cnt == $past(bit_cnt) + 5'h01;
   endproperty
   a_fall_mode: assert property (p_fall_mode)
      else $error("falling edge not sampled");

   property p_fsync;
      @(posedge ref_clk) disable iff (!nrst)
      state == ocdac_pkg::st_run && edge_s && !edge_d
         |=> frame_sync_mode [*3];
   endproperty
   a_fsync: assert property (p_fsync)
      else $error("frame-sync mode not entered");

   property p_msb_first;
      @(posedge ref_clk) disable iff (!nrst)
      shift_en |=> shreg == {$past(shreg[14:0]), $past(din_s)};
   endproperty
   a_msb_first: assert property (p_msb_first)
      else $error("shift order wrong");

   property p_load_input;
      @(posedge ref_clk) disable iff (!nrst)
      pop && !head_both && !update_run && !init_go
         |=> in_val[last_ch] == $past(head_code) &&
         out_val[last_ch] == $past(sel_out);
   endproperty
   a_load_input: assert property (p_load_input)
      else $error("input-only load disturbed output");

   property p_load_both;
      @(posedge ref_clk) disable iff (!nrst)
      pop && head_both |=> in_val[last_ch] == $past(head_code) &&
         out_val[last_ch] == $past(head_code);
   endproperty
   a_load_both: assert property (p_load_both)
      else $error("combined load failed");

   property p_update;
      @(posedge ref_clk) disable iff (!nrst)
      update_run && !pop && !init_go |=> out_val[0] == $past(in_val[0]);
   endproperty
   a_update: assert property (p_update)
      else $error("output not copied from input");

   property p_init;
      @(posedge ref_clk) disable iff (!nrst)
      init_go |=> ready && out_val[CHANNELS-1] == $past(init_code) &&
         in_val[0] == $past(init_code);
   endproperty
   a_init: assert property (p_init)
      else $error("power-up code not loaded");
endmodule

/* File: ocdac_regs.svh */
// constants for the octal dac serial write port
`ifndef OCDAC_REGS_SVH
`define OCDAC_REGS_SVH
`define OCDAC_FRAME_BITS 5'h10
`define OCDAC_LAST_BIT 5'h0F
`define OCDAC_CMD_MSB 15
`define OCDAC_CMD_LSB 12
`define OCDAC_CODE_MSB 11
`define OCDAC_CODE_MAX_BITS 12
`define OCDAC_BOTH_BIT 3
`define OCDAC_CHANNELS 8
`define OCDAC_INIT_WAIT 2'h3
`define OCDAC_SYNC_RESET 6'h02
`define OCDAC_BUF_FULL 2'h2
`endif

/* File: ocdac_pkg.sv */
// types for the octal dac serial write port
package ocdac_pkg;
   typedef enum logic {st_init, st_run} ocdac_state_t;
   typedef enum logic [1:0] {pu_zero, pu_mid, pu_full} ocdac_pu_t;
endpackage

/* File: ocdac_ch_if.sv */
// carrier between the port logic and one channel register pair
`timescale 1ns/10ps
interface ocdac_ch_if #(parameter int W = 12);
   logic load_in;
   logic load_out;
   logic copy;
   logic init;
   logic [W-1:0] code;
   logic [W-1:0] init_code;
   logic [W-1:0] in_reg;
   logic [W-1:0] out_reg;
   modport ctrl (output load_in, output load_out, output copy, output init,
      output code, output init_code, input in_reg, input out_reg);
   modport chan (input load_in, input load_out, input copy, input init,
      input code, input init_code, output in_reg, output out_reg);
endinterface

/* File: ocdac_chan_reg.sv */
// input and output register pair of one channel
`timescale 1ns/10ps
module ocdac_chan_reg #(
   parameter int W = 12
) (
   // clock and reset
   input wire logic ref_clk,
   input wire logic nrst,
   // control and data
   ocdac_ch_if.chan bus
);
   // holding register
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         bus.in_reg <= '0;
      end else if (bus.init) begin
         bus.in_reg <= bus.init_code;
      end else if (bus.load_in) begin
         bus.in_reg <= bus.code;
      end
   end

   // register that drives the converter
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         bus.out_reg <= '0;
      end else if (bus.init) begin
         bus.out_reg <= bus.init_code;
      end else if (bus.load_out) begin
         bus.out_reg <= bus.code;
      end else if (bus.copy) begin
         bus.out_reg <= bus.in_reg;
      end
   end
endmodule

/* File: ocdac_host.sv */
// host serial master model for the write port
`timescale 1ns/10ps
module ocdac_host (
   // clock
   input wire logic ref_clk,
   // serial pins
   output logic sclk,
   output logic cs_n,
   output logic din
);
   initial begin
      sclk = 1'h0;
      cs_n = 1'h1;
      din = 1'h0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk);
   endtask
   // one bit, value a at the rise and b at the fall
   task automatic put(input logic a, input logic b);
      din <= a;
      tick(2);
      sclk <= 1'h1;
      tick(2);
      din <= b;
      tick(2);
      sclk <= 1'h0;
      tick(2);
   endtask
   // frame of n bits, optional pause after a byte
   task automatic frame(input logic [15:0] wr, input logic [15:0] wf,
         input int n, input logic split);
      logic [15:0] r;
      logic [15:0] f;
      r = wr;
      f = wf;
      cs_n <= 1'h0;
      tick(4);
      for (int i = 0; i < n; i++) begin
         put(r[15], f[15]);
         r = {r[14:0], 1'h1};
         f = {f[14:0], 1'h1};
         if (split && i == 7)
            tick(10);
      end
      cs_n <= 1'h1;
      din <= ~din;
      tick(6);
   endtask
   // clock edges while deselected
   task automatic stray(input int n);
      repeat (n) put(1'h1, 1'h0);
   endtask
endmodule

/* File: testbench.sv */
// self-checking bench for the octal dac serial write port
`timescale 1ns/10ps
module testbench;
   logic ref_clk;
   logic nrst;
   logic sclk;
   logic cs_n;
   logic din;
   logic edge_sel;
   logic lvl;
   logic pu_open;
   logic apply_hold;
   logic update_all;
   logic [2:0] rdy;
   logic [2:0] sor;
   logic [2:0] fsm;
   logic [2:0] frdy;
   logic [2:0] ovr;
   logic [95:0] oc [3];
   int err_count;
   int cmp_count;
   ocdac_host ocdac_host_i (.ref_clk(ref_clk), .sclk(sclk), .cs_n(cs_n),
      .din(din));
   for (genvar g = 0; g < 3; g++) begin : g_var
      logic [(12 - 2 * g) * 8 - 1:0] code_v;
      assign oc[g] = 96'(code_v);
      ocdac_serial_port #(.CODE_BITS(12 - 2 * g)) ocdac_serial_port_i (
         .ref_clk(ref_clk), .nrst(nrst), .sclk(sclk), .cs_n(cs_n),
         .din(din), .edge_sel(edge_sel), .power_up_level_strap(lvl),
         .pu_open(pu_open), .apply_hold(apply_hold),
         .update_all(update_all), .ready(rdy[g]),
         .sample_on_rise(sor[g]), .frame_sync_mode(fsm[g]),
         .frame_ready(frdy[g]), .overrun(ovr[g]),
         .out_code(code_v));
   end
   initial begin
      ref_clk = 1'h0;
      forever #20 ref_clk = ~ref_clk;
   end
   task automatic complete_run;
      if (err_count == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string n, input logic [11:0] e,
         input logic [11:0] s);
      cmp_count++;
      if (s !== e) begin
         err_count++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic flag(input string n, input logic e, input logic [2:0] s);
      chk(n, {9'h000, {3{e}}}, {9'h000, s});
   endtask
   function automatic logic [11:0] chv(input int g, input int ch);
      logic [95:0] t;
      t = oc[g] >> (ch * (12 - 2 * g));
      return t[11:0] & (12'hFFF >> (2 * g));
   endfunction
   // one channel of every variant against a twelve-bit code
   task automatic chan(input int ch, input logic [11:0] v);
      for (int g = 0; g < 3; g++)
         chk($sformatf("ch%0d var%0d", ch, g), v >> (2 * g), chv(g, ch));
   endtask
   task automatic boot(input logic es, input logic lv, input logic op);
      nrst <= 1'h0;
      edge_sel <= es;
      lvl <= lv;
      pu_open <= op;
      repeat (12) @(posedge ref_clk);
      nrst <= 1'h1;
      repeat (8) @(posedge ref_clk);
   endtask
   task automatic send(input logic [15:0] wr, input logic [15:0] wf,
         input int n, input logic split);
      ocdac_host_i.frame(wr, wf, n, split);
      repeat (6) @(posedge ref_clk);
   endtask
   initial begin
      repeat (40000) @(posedge ref_clk);
      err_count++;
      complete_run();
   end
   initial begin
      apply_hold = 1'h0;
      update_all = 1'h0;
      err_count = 0;
      cmp_count = 0;
      boot(1'h1, 1'h1, 1'h0);
      flag("ready", 1'h1, rdy);
      flag("sample_on_rise", 1'h1, sor);
      flag("frame_sync_mode", 1'h0, fsm);
      flag("frame_ready", 1'h1, frdy);
      for (int c = 0; c < 8; c++)
         chan(c, 12'hFFF);
      send(16'h8ABC, 16'h8123, 16, 1'h0);
      chan(0, 12'hABC);
      send(16'h1555, 16'h1555, 16, 1'h0);
      chan(1, 12'hFFF);
      update_all <= 1'h1;
      @(posedge ref_clk);
      update_all <= 1'h0;
      repeat (3) @(posedge ref_clk);
      chan(1, 12'h555);
      chan(0, 12'hABC);
      send(16'h9F0F, 16'h9F0F, 16, 1'h1);
      chan(1, 12'hF0F);
      send(16'hA777, 16'hA777, 12, 1'h0);
      chan(2, 12'hFFF);
      ocdac_host_i.stray(4);
      repeat (8) @(posedge ref_clk);
      chan(2, 12'hFFF);
      send(16'hA240, 16'hA240, 20, 1'h0);
      chan(2, 12'h240);
      edge_sel <= 1'h0;
      repeat (6) @(posedge ref_clk);
      flag("frame_sync_mode", 1'h0, fsm);
      edge_sel <= 1'h1;
      repeat (6) @(posedge ref_clk);
      flag("frame_sync_mode", 1'h1, fsm);
      send(16'h8333, 16'h8444, 16, 1'h0);
      chan(0, 12'h444);
      boot(1'h0, 1'h0, 1'h0);
      flag("sample_on_rise", 1'h0, sor);
      flag("frame_sync_mode", 1'h0, fsm);
      flag("overrun", 1'h0, ovr);
      for (int c = 0; c < 8; c++)
         chan(c, 12'h000);
      send(16'h8111, 16'h8222, 16, 1'h0);
      chan(0, 12'h222);
      apply_hold <= 1'h1;
      send(16'hB001, 16'hB001, 16, 1'h0);
      send(16'hC002, 16'hC002, 16, 1'h0);
      flag("frame_ready", 1'h0, frdy);
      chan(3, 12'h000);
      send(16'hD003, 16'hD003, 16, 1'h0);
      flag("overrun", 1'h1, ovr);
      apply_hold <= 1'h0;
      repeat (8) @(posedge ref_clk);
      chan(3, 12'h001);
      chan(4, 12'h002);
      chan(5, 12'h000);
      flag("frame_ready", 1'h1, frdy);
      boot(1'h0, 1'h1, 1'h1);
      flag("overrun", 1'h0, ovr);
      for (int c = 0; c < 8; c++)
         chan(c, 12'h800);
      complete_run();
   end
endmodule
